// >>> core/drt_pkg.sv
package drt_pkg;
    typedef enum logic [2:0] {
        DRT_NOP, DRT_ACT, DRT_RD, DRT_WR, DRT_PRE, DRT_PREA, DRT_REF
    } drt_cmd_e;

    function automatic int drt_min_cyc(input int ps, input int period_ps);
        int c;
        c = (ps + period_ps - 1) / period_ps;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int drt_max_cyc(input int ps, input int period_ps);
        int c;
        c = ps / period_ps;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CLK_PERIOD_PS = 100_000;
    localparam int REFI_PS = 7_812_500;
    localparam int REFI_CYC = drt_max_cyc(REFI_PS, CLK_PERIOD_PS);
    localparam int REFI_HOT_CYC = drt_max_cyc(REFI_PS / 2, CLK_PERIOD_PS);
    localparam int REF_WINDOW_PS = 70_300_000;
    localparam int REF_WINDOW_CYC = drt_max_cyc(REF_WINDOW_PS, CLK_PERIOD_PS);
    localparam int REF_IN_WINDOW = 9;
    localparam int POSTPONE_MAX = REF_IN_WINDOW - 1;
    localparam int RFC_PS = 350_000;
    localparam int RFC_FAST_PS = 310_000;
    localparam int RFC_CYC = drt_min_cyc(RFC_PS, CLK_PERIOD_PS);
    localparam int RFC_FAST_CYC = drt_min_cyc(RFC_FAST_PS, CLK_PERIOD_PS);
    localparam int PREA_LIMIT_PS = 40_000;
    localparam bit PREA_AFTER_REF = CLK_PERIOD_PS > PREA_LIMIT_PS;
    localparam bit NOP_BETWEEN_REF = CLK_PERIOD_PS > RFC_PS;
    localparam int RAS_PS = 35_000;
    localparam int RAS_CYC = drt_min_cyc(RAS_PS, CLK_PERIOD_PS);
    localparam int WR_PS = 15_000;
    localparam int WR_MIN_CK = 4;
    localparam int WR_NORM_CYC = drt_min_cyc(WR_PS, CLK_PERIOD_PS);
    localparam int WR_DLLOFF_CYC = (WR_NORM_CYC > WR_MIN_CK) ? WR_NORM_CYC : WR_MIN_CK;
    localparam int WRITE_LATENCY = 5;
    localparam int WR_START_BURST8 = 4;
    localparam int WR_START_CHOP_FIXED = 2;
    localparam int REFPDEN_CYC = 1;
    localparam int XPDLL_PS = 24_000;
    localparam int XPDLL_MIN_CK = 10;
    localparam int XPDLL_CYC = (drt_min_cyc(XPDLL_PS, CLK_PERIOD_PS) > XPDLL_MIN_CK) ?
        drt_min_cyc(XPDLL_PS, CLK_PERIOD_PS) : XPDLL_MIN_CK;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_REFCNT = 8'h0C;
    localparam int CTRL_RESET_RELEASE = 0;
    localparam int CTRL_REF_EN = 1;
    localparam int CTRL_DLL_OFF = 2;
    localparam int CTRL_FIXED_CHOP = 3;
    localparam int CTRL_FAST_RFC = 4;
    localparam int CTRL_PD_REQ = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_AUTOCLOSE = 3;
    localparam int CMD_CHOP = 4;
    localparam int STAT_PENDING = 0;
    localparam int STAT_LOCKED = 1;
    localparam int STAT_POSTPONED_LSB = 2;
    localparam int STAT_PD = 6;
    localparam int STAT_HOT = 7;
endpackage

// >>> core/drt_if.sv
`timescale 1ns/1ns
interface drt_if;
    import drt_pkg::*;
    logic mem_reset_n;
    logic cke;
    drt_cmd_e cmd;
    logic autoclose;
    logic chop;
    logic dll_off;
    logic fixed_chop;
    logic fast_rfc;
    logic dll_locked;

    modport ctrl (
        output mem_reset_n, cke, cmd, autoclose, chop, dll_off, fixed_chop, fast_rfc,
        input dll_locked
    );
    modport mem (
        input mem_reset_n, cke, cmd, autoclose, chop, dll_off, fixed_chop, fast_rfc,
        output dll_locked
    );
endinterface

// >>> core/drt_mem.sv
`timescale 1ns/1ns
module drt_mem (
    input wire logic pclk,
    input wire logic presetn,
    drt_if.mem link,
    output logic internal_precharge,
    output logic wr_recovery_start,
    output logic wr_recovery_done,
    output logic refresh_busy,
    output logic outputs_at_risk,
    output logic timing_violation
);
    import drt_pkg::*;

    logic [7:0] ras_cnt;
    logic ap_pend;
    logic [7:0] wr_dly;
    logic wr_dly_run;
    logic wr_start_now;
    logic [7:0] wr_cnt;
    logic [7:0] rfc_cnt;
    logic reset_seen;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_seen <= 1'b0;
        else if (!link.mem_reset_n)
            reset_seen <= 1'b1;
    end

    assign outputs_at_risk = ~reset_seen;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            link.dll_locked <= 1'b0;
        else
            link.dll_locked <= reset_seen & link.mem_reset_n & ~link.dll_off;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ras_cnt <= 8'h00;
            ap_pend <= 1'b0;
            internal_precharge <= 1'b0;
        end
        else
        begin
            internal_precharge <= 1'b0;
            if (link.cmd == DRT_ACT)
                ras_cnt <= 8'(RAS_CYC);
            else if (ras_cnt != 8'h00)
                ras_cnt <= ras_cnt - 8'h01;
            if ((link.cmd == DRT_RD || link.cmd == DRT_WR) && link.autoclose)
                ap_pend <= 1'b1;
            else if (ap_pend && ras_cnt == 8'h00 && !wr_dly_run && wr_cnt == 8'h00)
            begin
                ap_pend <= 1'b0;
                internal_precharge <= 1'b1;
            end
        end
    end

    // recovery begins on the edge that sees the delay run out
    assign wr_start_now = wr_dly_run && (wr_dly == 8'h00) && (link.cmd != DRT_WR);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_dly <= 8'h00;
            wr_dly_run <= 1'b0;
            wr_recovery_start <= 1'b0;
        end
        else
        begin
            wr_recovery_start <= 1'b0;
            if (link.cmd == DRT_WR)
            begin
                wr_dly_run <= 1'b1;
                wr_dly <= link.fixed_chop ? 8'(WRITE_LATENCY + WR_START_CHOP_FIXED - 2) :
                    8'(WRITE_LATENCY + WR_START_BURST8 - 2);
            end
            else if (wr_dly_run)
            begin
                if (wr_dly == 8'h00)
                begin
                    wr_dly_run <= 1'b0;
                    wr_recovery_start <= 1'b1;
                end
                else
                    wr_dly <= wr_dly - 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_cnt <= 8'h00;
            wr_recovery_done <= 1'b0;
        end
        else
        begin
            wr_recovery_done <= 1'b0;
            if (wr_start_now)
                wr_cnt <= link.dll_off ? 8'(WR_DLLOFF_CYC) : 8'(WR_NORM_CYC);
            else if (wr_cnt != 8'h00)
            begin
                wr_cnt <= wr_cnt - 8'h01;
                wr_recovery_done <= (wr_cnt == 8'h01);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rfc_cnt <= 8'h00;
            timing_violation <= 1'b0;
        end
        else
        begin
            timing_violation <= (rfc_cnt != 8'h00) && (link.cmd != DRT_NOP);
            if (link.cmd == DRT_REF)
                rfc_cnt <= link.fast_rfc ? 8'(RFC_FAST_CYC) : 8'(RFC_CYC);
            else if (rfc_cnt != 8'h00)
                rfc_cnt <= rfc_cnt - 8'h01;
        end
    end

    assign refresh_busy = (rfc_cnt != 8'h00);
endmodule

// >>> core/drt_ctrl.sv
// Function
// - memory delays autoclose until row time met
// - dll off write recovery is max(4ck,15ns)
// - burst8 and chop-per-command start at wl+4
// - fixed chop recovery starts at wl+2
// - hold memory reset low from power-up
// - average refresh every 7.8125 us
// - nine refreshes within every 70.3 us
// - hot range halves the refresh interval
// - clock enable low after refresh delays
// - nop between refreshes on slow clock
// - precharge all after refresh below 25MHz
// - spread accesses evenly over rows (not enforced: commands go out in the order software writes them)
// - refresh cycle 350ns, optional 310ns
// - minimums round up, maximums round down
// - reads only while loop is locked
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module drt_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic temp_hot,
    drt_if.ctrl link
);
    import drt_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RFC, ST_PREA, ST_PD} drt_state_e;

    drt_state_e state;
    logic [5:0] ctrl;
    logic [4:0] cmd_q;
    logic cmd_pending;
    logic hot_s1, hot_s2, hot_s3, hot;
    logic [7:0] refi_cnt;
    logic [3:0] postponed;
    logic [7:0] rfc_cnt;
    logic [7:0] pden_cnt;
    logic [7:0] xp_cnt;
    logic [31:0] ref_total;
    logic wr_acc;
    logic tick;
    logic ref_go;
    logic cmd_go;
    logic pd_go;
    logic pd_exit;
    logic ref_urgent;
    logic mem_live;

    function automatic logic at(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // memory counts as released only while software still asks for it
    assign mem_live = link.mem_reset_n && ctrl[CTRL_RESET_RELEASE];
    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            if (at(paddr, OFF_CTRL))
                prdata <= {26'h0, ctrl};
            else if (at(paddr, OFF_CMD))
                prdata <= {27'h0, cmd_q};
            else if (at(paddr, OFF_STAT))
            begin
                prdata[STAT_PENDING] <= cmd_pending;
                prdata[STAT_LOCKED] <= link.dll_locked;
                prdata[STAT_POSTPONED_LSB +: 4] <= postponed;
                prdata[STAT_PD] <= (state == ST_PD);
                prdata[STAT_HOT] <= hot;
            end
            else if (at(paddr, OFF_REFCNT))
                prdata <= ref_total;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= CTRL_RESET;
        else if (wr_acc && at(paddr, OFF_CTRL))
            ctrl <= pwdata[5:0];
    end

    // a new command is ignored while one is pending; the clear wins over a write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_q <= 5'h00;
            cmd_pending <= 1'b0;
        end
        else if (wr_acc && at(paddr, OFF_CMD) && !cmd_pending)
        begin
            cmd_q <= pwdata[4:0];
            cmd_pending <= 1'b1;
        end
        else if (cmd_go)
            cmd_pending <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hot_s1 <= 1'b0;
            hot_s2 <= 1'b0;
            hot_s3 <= 1'b0;
            hot <= 1'b0;
        end
        else
        begin
            hot_s1 <= temp_hot;
            hot_s2 <= hot_s1;
            hot_s3 <= hot_s2;
            if (hot_s2 == hot_s3)
                hot <= hot_s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            refi_cnt <= 8'h00;
        else if (!ctrl[CTRL_REF_EN] || tick)
            refi_cnt <= 8'h00;
        else
            refi_cnt <= refi_cnt + 8'h01;
    end

    assign tick = ctrl[CTRL_REF_EN] &&
        (refi_cnt >= (hot ? 8'(REFI_HOT_CYC - 1) : 8'(REFI_CYC - 1)));

    assign ref_urgent = postponed >= 4'(POSTPONE_MAX);
    assign ref_go = (state == ST_IDLE) && mem_live && link.cke && xp_cnt == 8'h00 &&
        postponed != 4'h0 && (!cmd_pending || ref_urgent);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            postponed <= 4'h0;
        else if (tick && !ref_go && !ref_urgent)
            postponed <= postponed + 4'h1;
        else if (ref_go && !tick)
            postponed <= postponed - 4'h1;
    end

    assign cmd_go = (state == ST_IDLE) && mem_live && link.cke && cmd_pending && !ref_go &&
        xp_cnt == 8'h00 &&
        !(drt_cmd_e'(cmd_q[2:0]) == DRT_RD && (!link.dll_locked || link.dll_off)) &&
        drt_cmd_e'(cmd_q[2:0]) != DRT_REF;

    assign pd_go = (state == ST_IDLE) && ctrl[CTRL_PD_REQ] && !cmd_pending && !ref_go &&
        pden_cnt == 8'h00 && xp_cnt == 8'h00 && mem_live;
    assign pd_exit = (state == ST_PD) && (!ctrl[CTRL_PD_REQ] || ref_urgent);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            rfc_cnt <= 8'h00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (ref_go)
                    begin
                        state <= ST_RFC;
                        rfc_cnt <= ctrl[CTRL_FAST_RFC] ? 8'(RFC_FAST_CYC) : 8'(RFC_CYC);
                    end
                    else if (pd_go)
                        state <= ST_PD;
                end
                ST_RFC:
                begin
                    if (rfc_cnt > 8'h01)
                        rfc_cnt <= rfc_cnt - 8'h01;
                    else
                        state <= PREA_AFTER_REF ? ST_PREA : ST_IDLE;
                end
                ST_PREA:
                    state <= ST_IDLE;
                ST_PD:
                begin
                    if (pd_exit)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pden_cnt <= 8'h00;
            xp_cnt <= 8'h00;
        end
        else
        begin
            if (ref_go)
                pden_cnt <= 8'(REFPDEN_CYC + (NOP_BETWEEN_REF ? 1 : 0));
            else if (pden_cnt != 8'h00 && state == ST_IDLE)
                pden_cnt <= pden_cnt - 8'h01;
            // clock enable rising, from reset release or power-down, opens the quiet time
            if (pd_exit || (mem_live && !link.cke))
                xp_cnt <= 8'(XPDLL_CYC);
            else if (xp_cnt != 8'h00)
                xp_cnt <= xp_cnt - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.mem_reset_n <= 1'b0;
            link.cke <= 1'b0;
            link.cmd <= DRT_NOP;
            link.autoclose <= 1'b0;
            link.chop <= 1'b0;
            link.dll_off <= 1'b0;
            link.fixed_chop <= 1'b0;
            link.fast_rfc <= 1'b0;
            ref_total <= 32'h0000_0000;
        end
        else
        begin
            link.mem_reset_n <= ctrl[CTRL_RESET_RELEASE];
            link.dll_off <= ctrl[CTRL_DLL_OFF];
            link.fixed_chop <= ctrl[CTRL_FIXED_CHOP];
            link.fast_rfc <= ctrl[CTRL_FAST_RFC];
            link.cke <= mem_live && !pd_go && !(state == ST_PD && !pd_exit);
            link.cmd <= DRT_NOP;
            link.autoclose <= 1'b0;
            link.chop <= 1'b0;
            if (ref_go)
            begin
                link.cmd <= DRT_REF;
                ref_total <= ref_total + 32'h0000_0001;
            end
            else if (state == ST_PREA && ctrl[CTRL_RESET_RELEASE])
                link.cmd <= DRT_PREA;
            else if (cmd_go)
            begin
                link.cmd <= drt_cmd_e'(cmd_q[CMD_CODE_LSB +: 3]);
                link.autoclose <= cmd_q[CMD_AUTOCLOSE];
                link.chop <= cmd_q[CMD_CHOP];
            end
        end
    end
endmodule

// >>> bench/drt_sva.sv
`timescale 1ns/1ns
module drt_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_reset_n,
    input wire logic cke,
    input wire drt_pkg::drt_cmd_e cmd,
    input wire logic autoclose,
    input wire logic chop,
    input wire logic dll_off,
    input wire logic fixed_chop,
    input wire logic fast_rfc,
    input wire logic dll_locked
);
    import drt_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_cke_after_reset: assert property (cke |-> mem_reset_n)
        else $error("cke high while memory held in reset");
    a_reset_no_cmd: assert property (!mem_reset_n |-> cmd == DRT_NOP)
        else $error("command sent while memory held in reset");
    a_ref_rfc_quiet: assert property (cmd == DRT_REF |=> (cmd == DRT_NOP) [*4])
        else $error("command inside refresh cycle");
    a_ref_gap_nop: assert property (cmd == DRT_REF |=> cmd != DRT_REF)
        else $error("refresh directly after refresh");
    a_ref_then_prea: assert property (cmd == DRT_REF |-> ##5 cmd == DRT_PREA)
        else $error("refresh not followed by precharge all");
    a_read_locked: assert property (cmd == DRT_RD |-> dll_locked)
        else $error("read while loop unlocked");
    a_dll_off_unlock: assert property (dll_off |=> !dll_locked)
        else $error("loop reported locked while disabled");
    a_ref_cke_held: assert property (cmd == DRT_REF |=> cke)
        else $error("clock enable dropped right after refresh");
    a_exit_quiet: assert property ($rose(cke) |-> (cmd == DRT_NOP) [*8])
        else $error("command inside power-down exit delay");

    c_refresh: cover property (cmd == DRT_REF);
    c_read: cover property (cmd == DRT_RD);
    c_pd_exit: cover property ($rose(cke));
endmodule

// >>> bench/dram_refresh_recovery_timing_bench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module dram_refresh_recovery_timing_bench;
    import drt_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic temp_hot = 1'b0;
    logic tv_seen = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, internal_precharge, wr_recovery_start, wr_recovery_done;
    logic refresh_busy, outputs_at_risk, timing_violation;
    logic [7:0] adr [4] = '{OFF_CTRL, OFF_STAT, OFF_REFCNT, 8'h10};
    logic [31:0] ctl [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0009, 32'h0000_0005};
    int err_count = 0;
    int checks_done = 0;
    int n, es, ed;

    drt_if link_if ();
    drt_ctrl drt_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .temp_hot, .link(link_if.ctrl));
    drt_mem drt_mem_inst (.pclk, .presetn, .link(link_if.mem), .internal_precharge,
        .wr_recovery_start, .wr_recovery_done, .refresh_busy, .outputs_at_risk,
        .timing_violation);
    drt_sva drt_sva_inst (.pclk, .presetn, .mem_reset_n(link_if.mem_reset_n),
        .cke(link_if.cke), .cmd(link_if.cmd), .autoclose(link_if.autoclose),
        .chop(link_if.chop), .dll_off(link_if.dll_off), .fixed_chop(link_if.fixed_chop),
        .fast_rfc(link_if.fast_rfc), .dll_locked(link_if.dll_locked));

    always #50 pclk = ~pclk;

    always @(posedge pclk)
    begin
        if (timing_violation === 1'b1)
            tv_seen <= 1'b1;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return wr_recovery_start;
            1: return wr_recovery_done;
            2: return internal_precharge;
            3: return link_if.cmd == DRT_REF;
            4: return link_if.cmd == DRT_PREA;
            5: return link_if.cmd == DRT_WR;
            6: return link_if.cmd == DRT_RD;
            7: return !link_if.cke;
            default: return link_if.cke;
        endcase
    endfunction

    // edges until the chosen event is seen
    task automatic cnt(input int k, output int c);
        c = 0;
        do
        begin
            @(posedge pclk);
            c++;
        end
        while (sig(k) !== 1'b1 && c < 1000);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge pclk);
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        `CHK("at_risk", 1'b1, outputs_at_risk)
        `CHK("mem_reset_n", 1'b0, link_if.mem_reset_n)
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        foreach (adr[i])
        begin
            apb(1'b0, adr[i], 32'h0000_0000);
            `CHK("reg reset", 32'h0000_0000, rd)
        end
        `CHK("at_risk", 1'b0, outputs_at_risk)
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            es = WRITE_LATENCY + ((i == 2) ? WR_START_CHOP_FIXED : WR_START_BURST8);
            ed = (i == 3) ? WR_DLLOFF_CYC : WR_NORM_CYC;
            apb(1'b1, OFF_CTRL, ctl[i]);
            fork
                apb(1'b1, OFF_CMD, (i == 1) ? 32'h0000_0013 : 32'h0000_0003);
                begin
                    cnt(5, n);
                    cnt(0, n);
                    `CHK("wr start", es, n)
                    cnt(1, n);
                    `CHK("wr done", ed, n)
                end
            join
        end
        $display("test write recovery done");
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        apb(1'b1, OFF_CMD, 32'h0000_0001);
        do apb(1'b0, OFF_STAT, 32'h0000_0000); while (rd[STAT_PENDING] !== 1'b0);
        fork
            apb(1'b1, OFF_CMD, 32'h0000_000B);
            begin
                cnt(5, n);
                cnt(2, n);
                `CHK("precharge hold", 1'b1, n > es && n < 1000)
            end
        join
        $display("test autoclose done");
        apb(1'b1, OFF_CTRL, 32'h0000_0005);
        apb(1'b1, OFF_CMD, 32'h0000_0002);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        `CHK("rd held", 1'b1, rd[STAT_PENDING])
        `CHK("unlocked", 1'b0, rd[STAT_LOCKED])
        fork
            apb(1'b1, OFF_CTRL, 32'h0000_0001);
            cnt(6, n);
        join
        `CHK("rd issued", 1'b1, n < 1000)
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        `CHK("locked", 1'b1, rd[STAT_LOCKED])
        $display("test read lock done");
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        cnt(3, n);
        @(posedge pclk);
        `CHK("busy", 1'b1, refresh_busy)
        cnt(4, n);
        `CHK("ref to prea", RFC_CYC, n)
        cnt(3, n);
        `CHK("ref gap", REFI_CYC - RFC_CYC - 1, n)
        apb(1'b1, OFF_CTRL, 32'h0000_0013);
        cnt(3, n);
        cnt(4, n);
        `CHK("fast ref to prea", RFC_FAST_CYC + 1, n)
        temp_hot <= 1'b1;
        cnt(3, n);
        cnt(3, n);
        cnt(3, n);
        `CHK("hot ref gap", REFI_HOT_CYC, n)
        $display("test refresh done");
        apb(1'b1, OFF_CTRL, 32'h0000_0023);
        cnt(7, n);
        `CHK("cke low", 1'b1, n < 1000)
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        `CHK("pd state", 1'b1, rd[STAT_PD])
        `CHK("hot state", 1'b1, rd[STAT_HOT])
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        cnt(8, n);
        cnt(3, n);
        `CHK("exit delay", 1'b1, n >= XPDLL_CYC && n < 1000)
        `CHK("violation", 1'b0, tv_seen)
        $display("test power-down done");
        summarize();
    end
endmodule
